// *** logic/ssal_pkg.sv ***
// Shared constants and types for the state save area layout unit.
// Assumes a single core clock and a classic Wishbone register master.
package ssal_pkg;

  // Area geometry, in bytes from the save area base
  localparam logic [15:0] LEGACY_BYTES = 16'h0200;
  localparam logic [15:0] HDR_OFS = 16'h0200;
  localparam logic [15:0] HDR_COMPACT_OFS = 16'h0208;
  localparam logic [15:0] HDR_RSVD_OFS = 16'h0210;
  localparam logic [15:0] EXT_OFS = 16'h0240;
  localparam logic [15:0] ALIGN_MASK = 16'h003f;
  // Legacy fields
  localparam logic [15:0] FP_STATUS_OFS = 16'h0002;
  localparam logic [15:0] FP_TAG_OFS = 16'h0004;
  localparam logic [15:0] FP_RSVD_OFS = 16'h0005;
  localparam logic [15:0] FP_OPCODE_OFS = 16'h0006;
  localparam logic [15:0] FP_IP_OFS = 16'h0008;
  localparam logic [15:0] FP_DP_OFS = 16'h0010;
  localparam logic [15:0] VEC_CSR_OFS = 16'h0018;
  localparam logic [15:0] VEC_MASK_OFS = 16'h001c;
  localparam logic [15:0] FP_STACK_OFS = 16'h0020;
  localparam logic [15:0] VEC_REG_OFS = 16'h00a0;
  localparam logic [15:0] LEGACY_USED_END = 16'h01a0;
  localparam logic [15:0] LEGACY_RSVD_END = 16'h01d0;
  // Component numbering and bitmap layout
  localparam logic [5:0] COMP_FP = 6'h00;
  localparam logic [5:0] COMP_VEC128 = 6'h01;
  localparam logic [5:0] COMP_FIRST_EXT = 6'h02;
  localparam logic [5:0] COMP_LAST_EXT = 6'h3e;
  localparam int FMT_BIT = 63;
  // Enumerated sizes, standard offsets, alignment (values arbitrary except the wide upper halves)
  localparam logic [15:0] SIZE_WIDE = 16'h0100;
  localparam logic [15:0] SIZE_V512_MASK = 16'h0040;
  localparam logic [15:0] SIZE_V512_HI = 16'h0200;
  localparam logic [15:0] SIZE_V512_UP = 16'h0400;
  localparam logic [15:0] SIZE_PKEY = 16'h0008;
  localparam logic [15:0] STD_WIDE = 16'h0240;
  localparam logic [15:0] STD_V512_MASK = 16'h03c0;
  localparam logic [15:0] STD_V512_HI = 16'h0400;
  localparam logic [15:0] STD_V512_UP = 16'h0600;
  localparam logic [15:0] STD_PKEY = 16'h0a00;
  localparam logic [63:0] ALIGN_TABLE = 64'h0000_0000_0000_0240;
  // Register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_USER_MASK = 8'h04;
  localparam logic [7:0] REG_SUP_MASK = 8'h08;
  localparam logic [7:0] REG_SAVED_LO = 8'h0c;
  localparam logic [7:0] REG_SAVED_HI = 8'h10;
  localparam logic [7:0] REG_COMPACT_LO = 8'h14;
  localparam logic [7:0] REG_COMPACT_HI = 8'h18;
  localparam logic [7:0] REG_QUERY_IDX = 8'h1c;
  localparam logic [7:0] REG_QUERY_OFS = 8'h20;
  localparam logic [7:0] REG_QUERY_SIZE = 8'h24;
  localparam logic [7:0] REG_EXT_SIZE = 8'h28;
  localparam logic [7:0] REG_PROBE_ADDR = 8'h2c;
  localparam logic [7:0] REG_PROBE_CLASS = 8'h30;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DONE_BIT = 1;
  localparam int QUERY_PRESENT_BIT = 31;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ssal_wb_req_t;

  // Field that a byte offset falls in
  typedef enum logic [4:0] {
    FLD_FP_CONTROL = 5'h00, FLD_FP_STATUS = 5'h01, FLD_FP_TAG = 5'h02, FLD_LEGACY_RSVD = 5'h03,
    FLD_FP_OPCODE = 5'h04, FLD_FP_IP = 5'h05, FLD_FP_DP = 5'h06, FLD_VEC_CSR = 5'h07,
    FLD_VEC_MASK = 5'h08, FLD_FP_STACK = 5'h09, FLD_VEC_REG = 5'h0a, FLD_LEGACY_UNUSED = 5'h0b,
    FLD_HDR_SAVED = 5'h0c, FLD_HDR_COMPACT = 5'h0d, FLD_HDR_RSVD = 5'h0e, FLD_EXTENDED = 5'h0f
  } ssal_field_t;

  function automatic logic [15:0] comp_size(input logic [5:0] i);
    case (i)
      6'h02: return SIZE_WIDE;
      6'h05: return SIZE_V512_MASK;
      6'h06: return SIZE_V512_HI;
      6'h07: return SIZE_V512_UP;
      6'h09: return SIZE_PKEY;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] comp_std_ofs(input logic [5:0] i);
    case (i)
      6'h01: return VEC_CSR_OFS;
      6'h02: return STD_WIDE;
      6'h05: return STD_V512_MASK;
      6'h06: return STD_V512_HI;
      6'h07: return STD_V512_UP;
      6'h09: return STD_PKEY;
      default: return 16'h0000;
    endcase
  endfunction

endpackage

// *** logic/ssal_layout.sv ***
// State save area layout unit: computes where each state component lives.
// Assumes a classic Wishbone master on clk_i and a synchronous reset.
//
// Added by the designer: register access over Wishbone and the register offsets.
module ssal_layout
  import ssal_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire ssal_wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Layout status
  output logic restore_compacted_o,
  output logic layout_busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Walk state machine types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WALK = 3'b010,
    ST_DONE = 3'b100
  } ssal_state_t;

  ssal_state_t state;
  logic [5:0] idx;
  logic cmp_mode;
  logic seen;
  logic [15:0] prev_end;
  logic [15:0] ext_end;
  logic [15:0] ext_size;
  logic [15:0] loc_mem [0:63];
  logic [63:0] present_mem;
  logic [31:0] user_mask;
  logic [31:0] sup_mask;
  logic [63:0] saved_bitmap;
  logic [63:0] compaction_bitmap;
  logic [5:0] query_idx;
  logic [15:0] probe_addr;
  logic wr_en;
  logic rd_en;
  logic start;
  logic [31:0] next_rd_data;
  logic [15:0] next_loc;
  logic [15:0] cur_size;
  logic cur_present;
  logic [15:0] cur_end;
  ssal_field_t probe_field;
  logic [3:0] probe_row;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one access per ack, ack drops the cycle after
  assign wr_en = wb_i.cyc && wb_i.stb && wb_i.we && wb_ack_o;
  assign rd_en = wb_i.cyc && wb_i.stb && !wb_i.we && !wb_ack_o;
  assign start = wr_en && (wb_i.adr == REG_CTRL) && wb_i.sel[0] && wb_i.dat[CTRL_START_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_i.cyc && wb_i.stb && !wb_ack_o;
    end
  end

  // Byte-lane merge for writes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Layout inputs; frozen while a walk runs so results stay coherent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      user_mask <= 32'h0000_0000;
      sup_mask <= 32'h0000_0000;
      compaction_bitmap <= 64'h0000_0000_0000_0000;
    end else if (wr_en && state != ST_WALK) begin
      case (wb_i.adr)
        REG_USER_MASK: user_mask <= wmerge(user_mask, wb_i.dat, wb_i.sel);
        REG_SUP_MASK: sup_mask <= wmerge(sup_mask, wb_i.dat, wb_i.sel);
        REG_COMPACT_LO: compaction_bitmap[31:0] <= wmerge(compaction_bitmap[31:0], wb_i.dat, wb_i.sel);
        REG_COMPACT_HI: compaction_bitmap[63:32] <= wmerge(compaction_bitmap[63:32], wb_i.dat, wb_i.sel);
        default: ;
      endcase
    end
  end

  // Header image and query/probe selectors
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      saved_bitmap <= 64'h0000_0000_0000_0000;
      query_idx <= 6'h00;
      probe_addr <= 16'h0000;
    end else if (wr_en) begin
      case (wb_i.adr)
        REG_SAVED_LO: saved_bitmap[31:0] <= wmerge(saved_bitmap[31:0], wb_i.dat, wb_i.sel);
        REG_SAVED_HI: saved_bitmap[63:32] <= wmerge(saved_bitmap[63:32], wb_i.dat, wb_i.sel);
        REG_QUERY_IDX: query_idx <= wb_i.sel[0] ? wb_i.dat[5:0] : query_idx;
        REG_PROBE_ADDR: probe_addr <= 16'(wmerge({16'h0000, probe_addr}, wb_i.dat, wb_i.sel));
        default: ;
      endcase
    end
  end

  assign restore_compacted_o = compaction_bitmap[FMT_BIT];
  assign layout_busy_o = (state == ST_WALK);

  ////////////////////////////////////////////////////////////////////////////
  // Placement of the component under the walk index
  always_comb begin
    // Only supported extended components carry a size
    cur_size = (idx >= COMP_FIRST_EXT) ? comp_size(idx) : 16'h0000;
    cur_present = cmp_mode ? compaction_bitmap[idx] : ((user_mask | sup_mask) >> idx) != 32'h0 && (cur_size != 16'h0000)
                  && ((user_mask | sup_mask) & (32'h1 << idx)) != 32'h0;
    if (idx < COMP_FIRST_EXT) begin
      next_loc = comp_std_ofs(idx);
    end else if (!cmp_mode) begin
      next_loc = comp_std_ofs(idx);
    end else if (!seen) begin
      next_loc = EXT_OFS;
    end else if (ALIGN_TABLE[idx]) begin
      next_loc = (prev_end + ALIGN_MASK) & ~ALIGN_MASK;
    end else begin
      next_loc = prev_end;
    end
    cur_end = next_loc + cur_size;
  end

  // Ascending walk over components 0 to 62
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      idx <= 6'h00;
      cmp_mode <= 1'b0;
    end else begin
      case (state)
        ST_IDLE, ST_DONE: begin
          if (start) begin
            state <= ST_WALK;
            idx <= COMP_FP;
            cmp_mode <= compaction_bitmap[FMT_BIT];
          end
        end
        ST_WALK: begin
          if (idx == COMP_LAST_EXT) begin
            state <= ST_DONE;
          end else begin
            idx <= idx + 6'h01;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Track the nearest lower present component
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen <= 1'b0;
      prev_end <= EXT_OFS;
      ext_end <= EXT_OFS;
    end else if (start && state != ST_WALK) begin
      seen <= 1'b0;
      prev_end <= EXT_OFS;
      ext_end <= EXT_OFS;
    end else if (state == ST_WALK && idx >= COMP_FIRST_EXT && cur_present) begin
      // Absent components leave the chain untouched
      seen <= cmp_mode ? 1'b1 : seen;
      prev_end <= cmp_mode ? cur_end : prev_end;
      ext_end <= (cur_end > ext_end) ? cur_end : ext_end;
    end
  end

  // Result table and extended size; cleared so a query before any walk reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < 64; k++) begin
        loc_mem[k] <= 16'h0000;
      end
    end else if (state == ST_WALK) begin
      loc_mem[idx] <= next_loc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      present_mem <= 64'h0000_0000_0000_0000;
    end else if (state == ST_WALK) begin
      present_mem[idx] <= (idx < COMP_FIRST_EXT) || cur_present;
    end
  end

  assign ext_size = ext_end - EXT_OFS;

  ////////////////////////////////////////////////////////////////////////////
  // Field classification of a byte offset in the area
  always_comb begin
    probe_row = 4'h0;
    // Everything below 512 is legacy region
    if (probe_addr >= LEGACY_BYTES) begin
      if (probe_addr < HDR_COMPACT_OFS) begin
        probe_field = FLD_HDR_SAVED;
      end else if (probe_addr < HDR_RSVD_OFS) begin
        probe_field = FLD_HDR_COMPACT;
      end else if (probe_addr < EXT_OFS) begin
        probe_field = FLD_HDR_RSVD;
      end else begin
        probe_field = FLD_EXTENDED;
      end
    end else if (probe_addr >= LEGACY_USED_END) begin
      probe_field = (probe_addr < LEGACY_RSVD_END) ? FLD_LEGACY_RSVD : FLD_LEGACY_UNUSED;
    end else if (probe_addr >= VEC_REG_OFS) begin
      probe_field = FLD_VEC_REG;
      probe_row = 4'((probe_addr - VEC_REG_OFS) >> 4);
    end else if (probe_addr >= FP_STACK_OFS) begin
      // Stack rows, upper six bytes reserved
      probe_row = 4'((probe_addr - FP_STACK_OFS) >> 4);
      probe_field = (probe_addr[3:0] >= 4'ha) ? FLD_LEGACY_RSVD : FLD_FP_STACK;
    end else if (probe_addr >= VEC_MASK_OFS) begin
      probe_field = FLD_VEC_MASK;
    end else if (probe_addr >= VEC_CSR_OFS) begin
      probe_field = FLD_VEC_CSR;
    end else if (probe_addr >= FP_DP_OFS) begin
      probe_field = FLD_FP_DP;
    end else if (probe_addr >= FP_IP_OFS) begin
      probe_field = FLD_FP_IP;
    end else if (probe_addr >= FP_OPCODE_OFS) begin
      probe_field = FLD_FP_OPCODE;
    end else if (probe_addr >= FP_RSVD_OFS) begin
      probe_field = FLD_LEGACY_RSVD;
    end else if (probe_addr >= FP_TAG_OFS) begin
      probe_field = FLD_FP_TAG;
    end else if (probe_addr >= FP_STATUS_OFS) begin
      probe_field = FLD_FP_STATUS;
    end else begin
      probe_field = FLD_FP_CONTROL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data; unmapped addresses read zero
  always_comb begin
    case (wb_i.adr)
      REG_CTRL: next_rd_data = {30'h0, state == ST_DONE, state == ST_WALK};
      REG_USER_MASK: next_rd_data = user_mask;
      REG_SUP_MASK: next_rd_data = sup_mask;
      REG_SAVED_LO: next_rd_data = saved_bitmap[31:0];
      REG_SAVED_HI: next_rd_data = saved_bitmap[63:32];
      REG_COMPACT_LO: next_rd_data = compaction_bitmap[31:0];
      REG_COMPACT_HI: next_rd_data = compaction_bitmap[63:32];
      REG_QUERY_IDX: next_rd_data = {26'h0, query_idx};
      REG_QUERY_OFS: next_rd_data = {present_mem[query_idx], 15'h0, loc_mem[query_idx]};
      REG_QUERY_SIZE: next_rd_data = {16'h0, comp_size(query_idx)};
      REG_EXT_SIZE: next_rd_data = {16'h0, ext_size};
      REG_PROBE_ADDR: next_rd_data = {16'h0, probe_addr};
      REG_PROBE_CLASS: next_rd_data = {20'h0, probe_row, 3'h0, probe_field};
      default: next_rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_en) begin
      wb_dat_o <= next_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o) // Bus handshake
    else $error("ack held longer than one cycle");
  // Restore form follows bit 63 write
  a_restore_form: assert property (wr_en && wb_i.adr == REG_COMPACT_HI && wb_i.sel[3] && state != ST_WALK
    |=> restore_compacted_o == $past(wb_i.dat[31]))
    else $error("restore form not following format bit");
  a_first_placed: assert property (state == ST_WALK && cmp_mode && idx >= COMP_FIRST_EXT && !seen
    |-> next_loc == EXT_OFS)
    else $error("first compacted component not at extended start");
  a_packed_next: assert property (state == ST_WALK && cmp_mode && seen && idx >= COMP_FIRST_EXT
    && !ALIGN_TABLE[idx] |-> next_loc == prev_end)
    else $error("packed component not adjacent");
  a_aligned_next: assert property (state == ST_WALK && cmp_mode && seen && ALIGN_TABLE[idx]
    |-> next_loc[5:0] == 6'h00 && next_loc >= prev_end && next_loc - prev_end < 16'h0040)
    else $error("aligned component misplaced");
  a_absent_skip: assert property (state == ST_WALK && cmp_mode && !compaction_bitmap[idx]
    |=> $stable(prev_end) && $stable(seen))
    else $error("absent component moved the chain");
  a_walk_order: assert property (state == ST_WALK && idx != COMP_LAST_EXT |=> state == ST_WALK
    && idx == $past(idx) + 6'h01)
    else $error("walk not ascending");
  a_tail_unused: assert property (probe_addr >= LEGACY_USED_END && probe_addr < LEGACY_BYTES
    |-> probe_field inside {FLD_LEGACY_RSVD, FLD_LEGACY_UNUSED})
    else $error("legacy tail classified as state");
  a_header_saved: assert property (probe_addr >= HDR_OFS && probe_addr < HDR_COMPACT_OFS
    |-> probe_field == FLD_HDR_SAVED)
    else $error("header bitmap bytes misclassified");

  c_walk_compact: cover property (state == ST_WALK && cmp_mode ##1 state == ST_DONE);
  c_walk_standard: cover property (state == ST_WALK && !cmp_mode ##1 state == ST_DONE);
  c_aligned_gap: cover property (state == ST_WALK && cmp_mode && seen && ALIGN_TABLE[idx] && next_loc != prev_end);
  c_probe_ext: cover property (probe_field == FLD_EXTENDED);

endmodule

// *** verification/ssal_wb_master.sv ***
// Classic Wishbone master standing in for the core side of the layout unit.
// Assumes a slave that acks every request; the bench watchdog cuts any hang short.
module ssal_wb_master
  import ssal_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  output ssal_wb_req_t wb_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial wb_o = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // One classic cycle, held until ack is sampled high at a rising edge
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel,
                      output logic [31:0] rdat);
    @(posedge clk_i);
    wb_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    do begin
      @(posedge clk_i);
    end while (wb_ack_i !== 1'b1);
    rdat = wb_dat_i;
    // Released lines show the inverse, so a stale value never looks valid
    wb_o <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: 4'h0, dat: ~dat};
  endtask
endmodule

// *** verification/ssal_layout_tb_top.sv ***
// Self-checking bench for the save area layout unit, with a queue-free integer model.
// Assumes the Wishbone master module drives the only request port of the unit.
module ssal_layout_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ssal_pkg::*;

  logic clk_i;
  logic rst_i;
  ssal_wb_req_t wb;
  logic [31:0] wb_dat;
  logic wb_ack;
  logic restore_compacted;
  logic busy;
  int num_errors;
  int n_tests;
  int seed;
  int sz[64];
  int sofs[64];
  int al[64];
  int eofs[64];
  int epres[64];
  int eext;
  logic [31:0] rd;
  logic [31:0] lo;
  logic [31:0] hi;
  int pofs[22] = '{0, 2, 4, 5, 6, 8, 16, 24, 28, 32, 42, 159, 160, 400, 415, 416, 463, 464, 512, 520, 528, 576};
  int pfld[22] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 3, 3, 10, 10, 10, 3, 3, 11, 12, 13, 14, 15};
  int prow[22] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 7, 0, 15, 15, 0, 0, 0, 0, 0, 0, 0};

  ssal_layout i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
    .restore_compacted_o(restore_compacted), .layout_busy_o(busy));
  ssal_wb_master i_mst (.clk_i(clk_i), .rst_i(rst_i), .wb_o(wb), .wb_dat_i(wb_dat), .wb_ack_i(wb_ack));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    i_mst.xfer(1'b1, a, d, 4'hf, dummy);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    i_mst.xfer(1'b0, a, 32'h0, 4'hf, d);
  endtask

  // Start the offset walk and wait a bounded time for it to finish
  task automatic walk();
    int n;
    wr(REG_CTRL, 32'h1);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (busy !== 1'b0 && n < 200);
    rdr(REG_CTRL, rd);
    chk("walk done", 32'h2, rd & 32'h3);
  endtask

  // Reference layout: standard uses fixed offsets, compacted packs upward with optional 64-byte alignment
  task automatic model(input bit cmp, input logic [63:0] bm);
    int prev;
    bit any;
    prev = 576;
    any = 0;
    eext = 0;
    for (int i = 2; i < 63; i++) begin
      epres[i] = cmp ? bm[i] : (sz[i] != 0 && bm[i]);
      if (epres[i] != 0) begin
        eofs[i] = !cmp ? sofs[i] : (!any ? 576 : (al[i] != 0 ? (prev + 63) / 64 * 64 : prev));
        prev = eofs[i] + sz[i];
        any = 1;
        if (prev - 576 > eext) eext = prev - 576;
      end
    end
  endtask

  // Compare the query answers for components 0 to 10 and the extended size with the model
  task automatic check_layout();
    for (int i = 0; i < 11; i++) begin
      wr(REG_QUERY_IDX, i);
      rdr(REG_QUERY_OFS, rd);
      chk("present bit", (i < 2) ? 1 : epres[i], rd[31]);
      if (i < 2 || epres[i] != 0) chk("offset", (i == 0) ? 0 : (i == 1) ? 24 : eofs[i], rd[15:0]);
      if (i >= 2 && epres[i] != 0 && al[i] != 0) chk("aligned offset", 0, rd[5:0]);
      rdr(REG_QUERY_SIZE, rd);
      if (i >= 2) chk("size", sz[i], rd);
    end
    rdr(REG_EXT_SIZE, rd);
    chk("extended size", eext, rd);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog, well beyond the expected run
  initial begin
    #500000;
    num_errors++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_i = 1'b1;
    num_errors = 0;
    n_tests = 0;
    seed = 32'h4cd44839;
    foreach (sz[i]) begin
      sz[i] = 0;
      sofs[i] = 0;
      al[i] = 0;
      eofs[i] = 0;
      epres[i] = 0;
    end
    sz[2] = 256;  sz[5] = 64;  sz[6] = 512;  sz[7] = 1024; sz[9] = 8;
    sofs[2] = 576; sofs[5] = 960; sofs[6] = 1024; sofs[7] = 1536; sofs[9] = 2560;
    al[6] = 1;
    al[9] = 1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 'h30; a += 4) begin
      rdr(a[7:0], rd);
      chk("reset value", 32'h0, rd);
    end
    chk("restore form", 32'h0, restore_compacted);
    $display("test reset done");
    // Byte classification across legacy region, header and extended start
    for (int k = 0; k < 22; k++) begin
      wr(REG_PROBE_ADDR, pofs[k]);
      rdr(REG_PROBE_CLASS, rd);
      chk("field class", pfld[k], rd[4:0]);
      if (pfld[k] == 9 || pfld[k] == 10) chk("row", prow[k], rd[11:8]);
    end
    $display("test probe done");
    // Header bitmaps keep both 32-bit halves independently
    for (int k = 0; k < 4; k++) begin
      lo = $random(seed);
      wr(REG_SAVED_LO + 8'(k * 4), lo);
      rdr(REG_SAVED_LO + 8'(k * 4), rd);
      chk("bitmap word", lo, rd);
    end
    $display("test bitmaps done");
    // Standard layout with compaction kept clear by software
    wr(REG_COMPACT_LO, 32'h0);
    wr(REG_COMPACT_HI, 32'h0);
    for (int t = 0; t < 3; t++) begin
      lo = $random(seed) | 32'h4;
      hi = $random(seed);
      wr(REG_USER_MASK, lo);
      wr(REG_SUP_MASK, hi);
      walk();
      chk("restore form", 32'h0, restore_compacted);
      model(1'b0, {32'h0, lo | hi});
      check_layout();
    end
    $display("test standard done");
    // Compacted layout over random supported components
    wr(REG_COMPACT_HI, 32'h8000_0000);
    for (int t = 0; t < 6; t++) begin
      lo = $random(seed) & 32'h0000_02e4;
      if (lo == 0) lo = 32'h40;
      wr(REG_COMPACT_LO, lo);
      walk();
      chk("restore form", 32'h1, restore_compacted);
      model(1'b1, {32'h8000_0000, lo});
      check_layout();
    end
    $display("test compacted done");
    // A bitmap write during the walk is acked and ignored
    wr(REG_CTRL, 32'h1);
    wr(REG_COMPACT_LO, 32'h4);
    rdr(REG_CTRL, rd);
    chk("busy mid walk", 32'h1, rd[0]);
    chk("busy pin", 32'h1, busy);
    walk();
    rdr(REG_COMPACT_LO, rd);
    chk("refused write", lo, rd);
    check_layout();
    // Byte enables keep unselected lanes
    hi = $random(seed);
    wr(REG_SUP_MASK, 32'h0);
    i_mst.xfer(1'b1, REG_SUP_MASK, hi, 4'h5, rd);
    rdr(REG_SUP_MASK, rd);
    chk("byte lanes", hi & 32'h00ff_00ff, rd);
    // Unmapped place reads zero and keeps nothing
    wr(8'h3c, 32'hffff_ffff);
    rdr(8'h3c, rd);
    chk("unmapped", 32'h0, rd);
    $display("test refusal done");
    summarize();
  end
endmodule
